// >>> verilog/gated_counter_timer_defs.svh
// Constants for the gated counter/timer channel
`ifndef GATED_COUNTER_TIMER_DEFS_SVH
`define GATED_COUNTER_TIMER_DEFS_SVH

`define GCT_CLK_HZ        250000000
`define GCT_REF_HZ        24000000
`define GCT_ACC_STEP      `GCT_REF_HZ
`define GCT_ACC_WRAP      `GCT_CLK_HZ
`define GCT_CNT_RESET     32'h0000_0000
`define GCT_DOUT_RESET    8'h00
`define GCT_PERIOD_RESET  32'h0000_0002
`define GCT_WIDTH_RESET   32'h0000_0001

`endif

// >>> verilog/gated_counter_timer_pkg.sv
// Types shared by the gated counter/timer modules
package gated_counter_timer_pkg;

   typedef enum logic [1:0] {
      MODE_EVENT = 2'h0,
      MODE_FREQ  = 2'h1,
      MODE_EDGE  = 2'h2,
      MODE_RATE  = 2'h3
   } ct_mode_t;

   typedef enum logic [2:0] {
      ST_IDLE = 3'b001,
      ST_WAIT = 3'b010,
      ST_RUN  = 3'b100
   } edge_state_t;

endpackage : gated_counter_timer_pkg

// >>> verilog/ref_tick_if.sv
// Reference tick carried from the generator to the counter core
interface ref_tick_if;
   logic tick;
   modport source (output tick);
   modport sink   (input  tick);
endinterface : ref_tick_if

// >>> verilog/ref_tick_gen.sv
// Fractional divider making a 24 MHz tick from the system clock
`include "gated_counter_timer_defs.svh"

module ref_tick_gen (
   input  wire logic   mclk_i,
   input  wire logic   resetn_i,
   ref_tick_if.source  tick_o
);
   // One spare bit so that acc plus STEP cannot overflow before the wrap
   localparam logic [28:0] STEP = 29'(`GCT_ACC_STEP);
   localparam logic [28:0] WRAP = 29'(`GCT_ACC_WRAP);

   logic [28:0] acc;
   logic [28:0] next_acc;
   logic        hit;
   logic        next_hit;

   // Phase accumulator: one tick each time it passes the clock rate
   always_comb begin
      next_hit = 1'b0;
      next_acc = acc + STEP;
      if (next_acc >= WRAP) begin
         next_acc = next_acc - WRAP;
         next_hit = 1'b1;
      end
   end

   always_ff @(posedge mclk_i) begin
      if (!resetn_i) begin
         acc <= 29'h0000_0000;
         hit <= 1'b0;
      end else begin
         acc <= next_acc;
         hit <= next_hit;
      end
   end

   assign tick_o.tick = hit;
endmodule : ref_tick_gen

// >>> verilog/gated_counter_timer.sv
// Single counter/timer channel with static digital output lines
//
// Notes on behaviour
// - One channel: event, frequency, edge, rate modes.
// - External gate: count falling edges while active.
// - Software gate: count every falling input edge.
// - Frequency: count input edges during gate pulse.
// - Edge mode: count reference from start to stop.
// - Start and stop edges selectable rise/fall.
// - Edge mode counts a 24 MHz reference.
// - Period uses two same-polarity consecutive edges.
// - Rate mode drives continuous pulses, optionally gated.
// - Output line follows its written bit level.
`include "gated_counter_timer_defs.svh"

module gated_counter_timer #(
   parameter int CW = 32,
   parameter int DW = 8
) (
   input  wire logic                                mclk_i,
   input  wire logic                                resetn_i,
   input  wire logic                                enable_i,
   input  wire gated_counter_timer_pkg::ct_mode_t   mode_i,
   input  wire logic                                ext_gate_en_i,
   input  wire logic                                gate_active_high_i,
   input  wire logic                                start_rising_i,
   input  wire logic                                stop_rising_i,
   input  wire logic [CW-1:0]                       period_i,
   input  wire logic [CW-1:0]                       width_i,
   input  wire logic                                out_active_low_i,
   input  wire logic                                count_in_i,
   input  wire logic                                gate_in_i,
   input  wire logic [DW-1:0]                       dout_bits_i,
   output logic                                     ct_out_o,
   output logic [CW-1:0]                            count_o,
   output logic                                     done_o,
   output logic                                     busy_o,
   output logic [DW-1:0]                            dout_o
);
   // -----------------------------------------------------------------
   // Reference tick for edge-to-edge timing
   // -----------------------------------------------------------------
   ref_tick_if tick_bus ();

   ref_tick_gen u_ref_tick (
      .mclk_i   (mclk_i),
      .resetn_i (resetn_i),
      .tick_o   (tick_bus)
   );

   // -----------------------------------------------------------------
   // Pin history
   // -----------------------------------------------------------------
   logic cin_last;
   logic next_cin_last;
   logic gate_last;
   logic next_gate_last;
   logic en_last;
   logic next_en_last;

   always_comb begin
      next_cin_last  = count_in_i;
      next_gate_last = gate_in_i;
      next_en_last   = enable_i;
   end

   // Reset copies the count and gate pins so that no false edge follows reset; en_last clears to 0
   always_ff @(posedge mclk_i) begin
      if (!resetn_i) begin
         cin_last  <= count_in_i;
         gate_last <= gate_in_i;
         en_last   <= 1'b0;
      end else begin
         cin_last  <= next_cin_last;
         gate_last <= next_gate_last;
         en_last   <= next_en_last;
      end
   end

   // -----------------------------------------------------------------
   // Edge and level decode
   // -----------------------------------------------------------------
   logic cin_fall;
   logic gate_rise;
   logic gate_fall;
   logic gate_act;
   logic gate_act_last;
   logic gate_open;
   logic start_ev;
   logic stop_ev;
   logic en_rise;
   logic meas_mode;
   logic is_event;
   logic is_freq;
   logic is_edge;
   logic is_rate;

   assign cin_fall      = cin_last & ~count_in_i;
   assign gate_rise     = gate_in_i & ~gate_last;
   assign gate_fall     = ~gate_in_i & gate_last;
   assign gate_act      = (gate_in_i == gate_active_high_i);
   assign gate_act_last = (gate_last == gate_active_high_i);
   assign gate_open     = !ext_gate_en_i || gate_act;
   assign start_ev      = start_rising_i ? gate_rise : gate_fall;
   assign stop_ev       = stop_rising_i ? gate_rise : gate_fall;
   assign en_rise       = enable_i & ~en_last;

   assign is_event  = (mode_i == gated_counter_timer_pkg::MODE_EVENT);
   assign is_freq   = (mode_i == gated_counter_timer_pkg::MODE_FREQ);
   assign is_edge   = (mode_i == gated_counter_timer_pkg::MODE_EDGE);
   assign is_rate   = (mode_i == gated_counter_timer_pkg::MODE_RATE);
   assign meas_mode = is_freq || is_edge;

   // -----------------------------------------------------------------
   // Counter and measurement control
   // -----------------------------------------------------------------
   gated_counter_timer_pkg::edge_state_t state;
   gated_counter_timer_pkg::edge_state_t next_state;
   logic [CW-1:0]                        count;
   logic [CW-1:0]                        next_count;
   logic                                 done;
   logic                                 next_done;
   logic                                 busy;
   logic                                 next_busy;

   always_comb begin
      next_state = state;
      next_count = count;
      next_done  = done;
      if (!enable_i) begin
         next_state = gated_counter_timer_pkg::ST_IDLE;
      end else if (en_rise) begin
         // A fresh start clears the count and any old result
         next_count = CW'(`GCT_CNT_RESET);
         next_done  = 1'b0;
         if (meas_mode) begin
            next_state = gated_counter_timer_pkg::ST_WAIT;
         end else begin
            next_state = gated_counter_timer_pkg::ST_IDLE;
         end
      end else if (is_event) begin
         next_state = gated_counter_timer_pkg::ST_IDLE;
         next_done  = 1'b0;
         if (cin_fall && gate_open) begin
            next_count = count + CW'(1);
         end
      end else if (is_freq) begin
         case (state)
            gated_counter_timer_pkg::ST_WAIT: begin
               if (gate_act && !gate_act_last) begin
                  next_state = gated_counter_timer_pkg::ST_RUN;
                  if (cin_fall) begin
                     next_count = count + CW'(1);
                  end
               end
            end
            gated_counter_timer_pkg::ST_RUN: begin
               if (gate_act) begin
                  if (cin_fall) begin
                     next_count = count + CW'(1);
                  end
               end else begin
                  next_state = gated_counter_timer_pkg::ST_IDLE;
                  next_done  = 1'b1;
               end
            end
            default: begin
               next_state = gated_counter_timer_pkg::ST_IDLE;
            end
         endcase
      end else if (is_edge) begin
         case (state)
            gated_counter_timer_pkg::ST_WAIT: begin
               if (start_ev) begin
                  next_state = gated_counter_timer_pkg::ST_RUN;
               end
            end
            gated_counter_timer_pkg::ST_RUN: begin
               if (tick_bus.tick) begin
                  next_count = count + CW'(1);
               end
               if (stop_ev) begin
                  next_state = gated_counter_timer_pkg::ST_IDLE;
                  next_done  = 1'b1;
               end
            end
            default: begin
               next_state = gated_counter_timer_pkg::ST_IDLE;
            end
         endcase
      end else begin
         // Rate mode: count is the phase within one output period
         next_state = gated_counter_timer_pkg::ST_IDLE;
         next_done  = 1'b0;
         if (gate_open) begin
            if (count >= period_i - CW'(1)) begin
               next_count = CW'(`GCT_CNT_RESET);
            end else begin
               next_count = count + CW'(1);
            end
         end
      end
      next_busy = enable_i &&
                  !(meas_mode && next_state == gated_counter_timer_pkg::ST_IDLE);
   end

   always_ff @(posedge mclk_i) begin
      if (!resetn_i) begin
         state <= gated_counter_timer_pkg::ST_IDLE;
         count <= CW'(`GCT_CNT_RESET);
         done  <= 1'b0;
         busy  <= 1'b0;
      end else begin
         state <= next_state;
         count <= next_count;
         done  <= next_done;
         busy  <= next_busy;
      end
   end

   // -----------------------------------------------------------------
   // Pulse output
   // -----------------------------------------------------------------
   logic ct_out;
   logic next_ct_out;

   // Active part of each period is the first width_i clocks
   always_comb begin
      next_ct_out = out_active_low_i;
      if (enable_i && is_rate && gate_open && count < width_i) begin
         next_ct_out = ~out_active_low_i;
      end
   end

   always_ff @(posedge mclk_i) begin
      if (!resetn_i) begin
         ct_out <= out_active_low_i;
      end else begin
         ct_out <= next_ct_out;
      end
   end

   // -----------------------------------------------------------------
   // Static output lines
   // -----------------------------------------------------------------
   logic [DW-1:0] dout;
   logic [DW-1:0] next_dout;

   for (genvar i = 0; i < DW; i++) begin : g_dout
      assign next_dout[i] = dout_bits_i[i];
   end

   always_ff @(posedge mclk_i) begin
      if (!resetn_i) begin
         dout <= DW'(`GCT_DOUT_RESET);
      end else begin
         dout <= next_dout;
      end
   end

   // -----------------------------------------------------------------
   // Outputs
   // -----------------------------------------------------------------
   assign count_o  = count;
   assign done_o   = done;
   assign busy_o   = busy;
   assign ct_out_o = ct_out;
   assign dout_o   = dout;
endmodule : gated_counter_timer

// >>> dv/gct_props.sv
// Port checks for the counter/timer channel
module gct_props (
   input wire logic        mclk_i,
   input wire logic        resetn_i,
   input wire logic [7:0]  dout_bits_i,
   input wire logic [7:0]  dout_o,
   input wire logic [31:0] count_o,
   input wire logic        enable_i,
   input wire logic [1:0]  mode_i,
   input wire logic        ext_gate_en_i,
   input wire logic        gate_active_high_i,
   input wire logic        gate_in_i,
   input wire logic        out_active_low_i,
   input wire logic        ct_out_o,
   input wire logic        done_o,
   input wire logic        busy_o
);
   timeunit 1ns; timeprecision 1ps;
   default clocking @(posedge mclk_i); endclocking
   default disable iff (!resetn_i);
   sequence meas_closed;
      done_o && !busy_o;
   endsequence
   enable_clear_a: assert property ($rose(enable_i) |=>
      count_o == 32'h0000_0000) else $error("count not cleared");
   event_gate_a: assert property (enable_i && $past(enable_i) &&
      mode_i == 2'h0 && ext_gate_en_i && gate_in_i != gate_active_high_i
      |=> count_o == $past(count_o)) else $error("count moved, gate shut");
   done_close_a: assert property (done_o |-> meas_closed)
      else $error("done while busy");
   rate_off_a: assert property (!enable_i |=>
      ct_out_o == $past(out_active_low_i)) else $error("output not idle");
   dout_follow_a: assert property ($stable(dout_bits_i)[*3] |->
      dout_o == dout_bits_i) else $error("dout wrong");
   count_step_a: assert property ($changed(count_o) |->
      count_o == $past(count_o) + 1 || count_o == 0) else $error("count jump");
endmodule : gct_props
bind gated_counter_timer gct_props u_props (.mclk_i(mclk_i),
   .resetn_i(resetn_i), .dout_bits_i(dout_bits_i), .dout_o(dout_o),
   .count_o(count_o), .enable_i(enable_i), .mode_i(mode_i),
   .ext_gate_en_i(ext_gate_en_i), .gate_active_high_i(gate_active_high_i),
   .gate_in_i(gate_in_i), .out_active_low_i(out_active_low_i),
   .ct_out_o(ct_out_o), .done_o(done_o), .busy_o(busy_o));

// >>> dv/pulse_src.sv
// Square-wave source on the count pin, idle high as if pulled up
module pulse_src (
   input  wire logic clk_i,
   input  wire logic run_i,
   output logic      pulse_o = 1'b1
);
   timeunit 1ns; timeprecision 1ps;
   always @(negedge clk_i) pulse_o <= run_i ? ~pulse_o : 1'b1;
endmodule : pulse_src

// >>> dv/tb_top.sv
// Self-checking bench for the counter/timer channel
`include "gated_counter_timer_defs.svh"
module tb_top;
   timeunit 1ns; timeprecision 1ps;
   // 125 clocks always hold a whole number of reference ticks
   localparam int EDGE_CLKS = 125;
   localparam int EDGE_EXP =
      int'(longint'(EDGE_CLKS) * `GCT_REF_HZ / `GCT_CLK_HZ);
   logic mclk_i = 0, resetn_i = 0, en = 0, xg = 0, ga = 1, run = 0, gt = 0, p;
   logic sr = 1, st = 1, done, busy, ct;
   gated_counter_timer_pkg::ct_mode_t md = gated_counter_timer_pkg::MODE_EVENT;
   logic [7:0] bits = 8'h00, dout;
   logic [31:0] cnt, q[$], hi_seen;
   logic [31:0] per = 32'h0000_0005, wid = 32'h0000_0002;
   int miscompares = 0, checks_done = 0, seed = 65, cyc = 0;
   event chk;
   always #2 mclk_i = ~mclk_i;
   pulse_src PS (.clk_i(mclk_i), .run_i(run), .pulse_o(p));
   gated_counter_timer DUT (.mclk_i(mclk_i), .resetn_i(resetn_i),
      .enable_i(en), .mode_i(md),
      .ext_gate_en_i(xg), .gate_active_high_i(ga), .start_rising_i(sr),
      .stop_rising_i(st), .period_i(per),
      .width_i(wid), .out_active_low_i(1'b0), .count_in_i(p),
      .gate_in_i(gt), .dout_bits_i(bits), .ct_out_o(ct), .count_o(cnt),
      .done_o(done), .busy_o(busy), .dout_o(dout));
   task automatic rst;
      resetn_i = 0;
      repeat (16) @(negedge mclk_i);
      resetn_i = 1;
   endtask : rst
   task automatic cmp_flag(input string n, input logic e, input logic s);
      checks_done++;
      if (e !== s) begin
         miscompares++;
         $display("Error %s exp %b seen %b", n, e, s);
      end
   endtask : cmp_flag
   task automatic cmp_pulse(input logic [31:0] e, input logic [31:0] s);
      checks_done++;
      if (e !== s) begin
         miscompares++;
         $display("Error pulse_high exp %0d seen %0d", e, s);
      end
   endtask : cmp_pulse
   task automatic cmp_dout(input logic [7:0] e, input logic [7:0] s);
      checks_done++;
      if (e !== s) begin
         miscompares++;
         $display("Error dout exp %h seen %h", e, s);
      end
   endtask : cmp_dout
   // Two gate pulses; frequency mode measures only the first, edge mode can span from the first to the second
   task automatic meas(input gated_counter_timer_pkg::ct_mode_t m,
      input logic s, t, input int hi, lo, input logic [31:0] e);
      md = m; sr = s; st = t; xg = 0; ga = 1; gt = 0; run = 1;
      rst;
      en = 1;
      repeat (4) @(negedge mclk_i);
      gt = 1;
      repeat (hi) @(negedge mclk_i);
      gt = 0;
      repeat (lo) @(negedge mclk_i);
      gt = 1;
      repeat (hi) @(negedge mclk_i);
      gt = 0;
      repeat (8) @(negedge mclk_i);
      run = 0;
      q.push_back(e);
      -> chk;
      cmp_flag("done", 1'b1, done);
      cmp_flag("busy", 1'b0, busy);
   endtask : meas
   task end_of_test;
      $display("checks %0d miscompares %0d", checks_done, miscompares);
      if (miscompares == 0 && checks_done > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask : end_of_test
   task automatic cmp(input logic [31:0] e, input logic [31:0] s);
      checks_done++;
      if (e !== s) begin
         miscompares++;
         $display("Error count exp %h seen %h", e, s);
      end
   endtask : cmp
   // Twenty toggling cycles give ten falling edges
   task automatic go(input logic x, a, g, input logic [31:0] e);
      md = gated_counter_timer_pkg::MODE_EVENT;
      rst;
      xg = x; ga = a; gt = g; en = 1;
      repeat (4) @(negedge mclk_i);
      run = 1;
      repeat (20) @(negedge mclk_i);
      run = 0;
      repeat (8) @(negedge mclk_i);
      q.push_back(e);
      -> chk;
   endtask : go
   always @chk cmp(q.pop_front(), cnt);
   always @(posedge mclk_i) if (++cyc > 3000) begin
      miscompares++;
      end_of_test;
   end
   initial begin
      go(0, 1, 0, 32'h0000_000a);
      go(1, 1, 1, 32'h0000_000a);
      go(1, 1, 0, 32'h0000_0000);
      go(1, 0, 0, 32'h0000_000a);
      meas(gated_counter_timer_pkg::MODE_FREQ, 1, 1, 20, 10, 32'h0000_000a);
      meas(gated_counter_timer_pkg::MODE_EDGE, 1, 1, 50, 75, EDGE_EXP);
      meas(gated_counter_timer_pkg::MODE_EDGE, 1, 0, 125, 10, EDGE_EXP);
      meas(gated_counter_timer_pkg::MODE_EDGE, 0, 0, 50, 75, EDGE_EXP);
      // Rate: 50 clocks are ten periods of five with two active each
      md = gated_counter_timer_pkg::MODE_RATE; xg = 0; gt = 0;
      rst;
      en = 1;
      repeat (10) @(negedge mclk_i);
      hi_seen = 0;
      repeat (50) begin
         @(negedge mclk_i);
         if (ct === 1'b1) hi_seen++;
      end
      cmp_pulse(32'h0000_0014, hi_seen);
      xg = 1; ga = 1;
      repeat (4) @(negedge mclk_i);
      hi_seen = 0;
      repeat (20) begin
         @(negedge mclk_i);
         if (ct !== 1'b0) hi_seen++;
      end
      cmp_pulse(32'h0000_0000, hi_seen);
      en = 0;
      repeat (4) @(negedge mclk_i);
      cmp_flag("ct_out", 1'b0, ct);
      bits = 8'($random(seed));
      repeat (3) @(negedge mclk_i);
      cmp_dout(bits, dout);
      end_of_test;
   end
endmodule : tb_top
